// >>> src/aoam_pkg.sv
/*
 * Shared constants and types for the sum-of-products array with eight output macrocells.
 * Assumes a single 40 MHz clock; all pins are sampled synchronously to it.
 */
`default_nettype none

package aoam_pkg;

    // Array geometry
    localparam int NUM_SIGNALS = 16;
    localparam int NUM_LINES = 32;
    localparam int NUM_TERMS = 64;
    localparam int TERMS_PER_GROUP = 8;
    localparam int NUM_CELLS = 8;
    localparam int NUM_DEDICATED = 8;
    localparam int FB_BASE = 8;

    // Term zero of a group may steer the driver instead of the sum
    localparam int OE_TERM_INDEX = 0;

    // Outermost macrocells
    localparam int OUTER_LOW = 0;
    localparam int OUTER_HIGH = 7;

    // Reset values
    localparam logic RESET_REG_Q = 1'b0;
    localparam logic RESET_PIN_OUT = 1'b0;
    localparam logic RESET_PIN_OE = 1'b0;
    localparam logic RESET_CLK_PREV = 1'b0;

    // Architecture configurations
    typedef enum logic [1:0] {
        simple_combinational_config = 2'b00,
        registered_config = 2'b01,
        mixed_io_config = 2'b10
    } aoam_mode_type;

    // Static architecture cells of one macrocell
    typedef struct packed {
        logic registered;
        logic active_high;
        logic use_oe_term;
        logic as_input;
    } aoam_cell_cfg_type;

    // Pin driver: level and enable
    typedef struct packed {
        logic out;
        logic oe;
    } aoam_pin_type;

endpackage : aoam_pkg

`default_nettype wire

// >>> src/aoam_term_group.sv
/*
 * One output group: eight wide AND product terms and their fixed OR.
 * Assumes fuse bits and array lines are stable during evaluation; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module aoam_term_group #(
    parameter int TERMS = 8,
    parameter int LINES = 32
) (
    // Array lines and fuse pattern of this group
    input wire logic [LINES-1:0] lines_i,
    input wire logic [TERMS-1:0][LINES-1:0] fuse_i,
    input wire logic use_oe_term_i,
    // Group results
    output logic sum_o,
    output logic oe_term_o
);
    import aoam_pkg::*;

    logic [TERMS-1:0] term;

    // A term is true while every connected line is high
    always_comb begin
        for (int t = 0; t < TERMS; t++) begin
            term[t] = &(~fuse_i[t] | lines_i);
        end
    end

    // Seven or eight terms summed; term zero may steer the driver instead
    always_comb begin
        sum_o = |term[TERMS-1:1] | (term[OE_TERM_INDEX] & ~use_oe_term_i);
        oe_term_o = use_oe_term_i ? term[OE_TERM_INDEX] : 1'b1;
    end

endmodule : aoam_term_group

`default_nettype wire

// >>> src/aoam_macrocell.sv
/*
 * One output macrocell: polarity, optional D flip-flop and pin driver selection.
 * Assumes reg_en_i is a one-cycle pulse at each rising edge of the register clock pin.
 */
`timescale 1ns/1ps
`default_nettype none

module aoam_macrocell (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Static configuration
    input wire aoam_pkg::aoam_mode_type mode_i,
    input wire aoam_pkg::aoam_cell_cfg_type cfg_i,
    // Array results and pins
    input wire logic sum_i,
    input wire logic oe_term_i,
    input wire logic reg_en_i,
    input wire logic oe_n_i,
    // Results
    output logic func_o,
    output logic q_o,
    output aoam_pkg::aoam_pin_type pin_o
);
    import aoam_pkg::*;

    logic q;
    logic next_q;
    aoam_pin_type pin;
    aoam_pin_type next_pin;

    // Polarity ahead of the flip-flop, capture and driver choice
    always_comb begin
        func_o = cfg_i.active_high ? sum_i : ~sum_i;
        next_q = q;
        if (reg_en_i) begin
            next_q = func_o;
        end
        next_pin.out = func_o;
        next_pin.oe = 1'b0;
        case (mode_i)
            registered_config: begin
                if (cfg_i.as_input) begin
                    next_pin.oe = 1'b0;
                end else if (cfg_i.registered) begin
                    next_pin.out = next_q;
                    next_pin.oe = ~oe_n_i;
                end else begin
                    next_pin.oe = oe_term_i;
                end
            end
            mixed_io_config: begin
                next_pin.oe = cfg_i.as_input ? 1'b0 : oe_term_i;
            end
            default: begin
                next_pin.oe = ~cfg_i.as_input;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= RESET_REG_Q;
            pin <= '{out: RESET_PIN_OUT, oe: RESET_PIN_OE};
        end else begin
            q <= next_q;
            pin <= next_pin;
        end
    end

    // Feedback is the register itself, whatever the driver does
    assign q_o = q;
    assign pin_o = pin;

endmodule : aoam_macrocell

`default_nettype wire

// >>> src/aoam_top.sv
/*
 * Programmable AND array with fixed OR gates feeding eight output macrocells.
 * Assumes fuse and architecture inputs are static while running and all pins are
 * synchronous to clk_i; the register clock pin is edge-detected into an enable.
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - 16 complementary inputs, 64 terms, 2048 cells
// - Each cell selects true or inverted input
// - Term true while all connected lines high
// - Eight groups of eight terms each
// - Seven or eight terms ORed, one may enable
// - Each sum feeds its own macrocell
// - Registered cell captures on clock rising edge
// - Selectable polarity applied before the register
// - Options come from static architecture cells
// - Exactly three architecture configurations
// - Simple config outputs always enabled, or inputs
// - Registered cell feeds flip-flop back into array
// - Bidirectional cell gated by term, pin feeds array
// - Mixed config outer cells three-state, no feedback
// - Input cell disables driver, passes pin value, except outer cells outside registered config
// - Registered config uses clock and enable pins
////////////////////////////////////////////////////////////////////////////////

module aoam_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Static architecture and fuse cells
    input wire aoam_pkg::aoam_mode_type mode_i,
    input wire aoam_pkg::aoam_cell_cfg_type [aoam_pkg::NUM_CELLS-1:0] cell_cfg_i,
    input wire logic [aoam_pkg::NUM_TERMS-1:0][aoam_pkg::NUM_LINES-1:0] fuse_i,
    // Dedicated inputs and the two special pins
    input wire logic [aoam_pkg::NUM_DEDICATED-1:0] in_i,
    input wire logic clk_pin_i,
    input wire logic oe_n_pin_i,
    // Macrocell pins
    input wire logic [aoam_pkg::NUM_CELLS-1:0] io_i,
    output aoam_pkg::aoam_pin_type [aoam_pkg::NUM_CELLS-1:0] pin_o
);
    import aoam_pkg::*;

    logic [NUM_SIGNALS-1:0] sig;
    logic [NUM_LINES-1:0] lines;
    logic [NUM_CELLS-1:0] sum;
    logic [NUM_CELLS-1:0] oe_term;
    logic [NUM_CELLS-1:0] func;
    logic [NUM_CELLS-1:0] q;
    logic [NUM_CELLS-1:0] fb;
    logic clk_prev;
    logic next_clk_prev;
    logic reg_en;
    logic is_reg_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Register clock pin edge detect

    // Only the registered configuration treats the pin as a clock
    always_comb begin
        is_reg_mode = (mode_i == registered_config);
        next_clk_prev = clk_pin_i;
        reg_en = is_reg_mode & clk_pin_i & ~clk_prev;
    end

    // Previous pin level
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clk_prev <= RESET_CLK_PREV;
        end else begin
            clk_prev <= next_clk_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Feedback selection into the array

    // Register, pin or special pin per macrocell
    always_comb begin
        for (int m = 0; m < NUM_CELLS; m++) begin
            if (is_reg_mode && cell_cfg_i[m].registered && !cell_cfg_i[m].as_input) begin
                fb[m] = q[m];
            end else if (!is_reg_mode && m == OUTER_LOW) begin
                fb[m] = clk_pin_i;
            end else if (!is_reg_mode && m == OUTER_HIGH) begin
                fb[m] = oe_n_pin_i;
            end else begin
                fb[m] = io_i[m];
            end
        end
    end

    // Sixteen signals in both phases
    always_comb begin
        sig = {fb, in_i};
        for (int k = 0; k < NUM_SIGNALS; k++) begin
            lines[2*k] = sig[k];
            lines[2*k+1] = ~sig[k];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Term groups and macrocells

    for (genvar g = 0; g < NUM_CELLS; g++) begin : g_cell
        // Eight terms of the 64 per group
        aoam_term_group #(
            .TERMS(TERMS_PER_GROUP),
            .LINES(NUM_LINES)
        ) u_group (
            .lines_i(lines),
            .fuse_i(fuse_i[g*TERMS_PER_GROUP +: TERMS_PER_GROUP]),
            .use_oe_term_i(cell_cfg_i[g].use_oe_term),
            .sum_o(sum[g]),
            .oe_term_o(oe_term[g])
        );

        // Mixed config allows no register anywhere
        aoam_cell_cfg_type cfg_eff;
        always_comb begin
            cfg_eff = cell_cfg_i[g];
            cfg_eff.registered = cell_cfg_i[g].registered & is_reg_mode;
            if (mode_i == mixed_io_config && (g == OUTER_LOW || g == OUTER_HIGH)) begin
                cfg_eff.as_input = 1'b0;
            end
        end

        // Each sum drives its own macrocell
        aoam_macrocell u_cell (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .mode_i(mode_i),
            .cfg_i(cfg_eff),
            .sum_i(sum[g]),
            .oe_term_i(oe_term[g]),
            .reg_en_i(reg_en),
            .oe_n_i(oe_n_pin_i),
            .func_o(func[g]),
            .q_o(q[g]),
            .pin_o(pin_o[g])
        );

        ////////////////////////////////////////////////////////////////////////
        // Checks per macrocell

        property p_capture;
            @(posedge clk_i) disable iff (!resetn_i)
            reg_en |=> q[g] == $past(func[g]);
        endproperty
        a_capture: assert property (p_capture) else $error("register missed capture");

        property p_hold;
            @(posedge clk_i) disable iff (!resetn_i)
            !reg_en |=> $stable(q[g]);
        endproperty
        a_hold: assert property (p_hold) else $error("register changed without edge");

        property p_simple_out;
            @(posedge clk_i) disable iff (!resetn_i)
            (mode_i == simple_combinational_config && !cell_cfg_i[g].as_input)
                |=> pin_o[g].oe && pin_o[g].out ==
                    $past(cell_cfg_i[g].active_high ? sum[g] : ~sum[g]);
        endproperty
        a_simple_out: assert property (p_simple_out) else $error("simple output wrong");

        property p_input_off;
            @(posedge clk_i) disable iff (!resetn_i)
            (cell_cfg_i[g].as_input && mode_i != mixed_io_config) |=> !pin_o[g].oe;
        endproperty
        a_input_off: assert property (p_input_off) else $error("input cell drives pin");

        property p_reg_enable;
            @(posedge clk_i) disable iff (!resetn_i)
            (is_reg_mode && cell_cfg_i[g].registered && !cell_cfg_i[g].as_input)
                |=> pin_o[g].oe == !$past(oe_n_pin_i) && pin_o[g].out == q[g];
        endproperty
        a_reg_enable: assert property (p_reg_enable) else $error("register pin wrong");

        property p_reg_feedback;
            @(posedge clk_i) disable iff (!resetn_i)
            (is_reg_mode && cell_cfg_i[g].registered && !cell_cfg_i[g].as_input)
                |-> sig[FB_BASE+g] == q[g];
        endproperty
        a_reg_feedback: assert property (p_reg_feedback) else $error("feedback lost");

        property p_io_gate;
            @(posedge clk_i) disable iff (!resetn_i)
            (mode_i == mixed_io_config && !cell_cfg_i[g].as_input)
                |=> pin_o[g].oe == $past(oe_term[g]);
        endproperty
        a_io_gate: assert property (p_io_gate) else $error("term enable ignored");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array wide checks

    property p_edge_enable;
        @(posedge clk_i) disable iff (!resetn_i)
        ##1 (is_reg_mode && $rose(clk_pin_i)) |-> reg_en;
    endproperty
    a_edge_enable: assert property (p_edge_enable) else $error("clock edge missed");

    property p_no_clock;
        @(posedge clk_i) disable iff (!resetn_i)
        !is_reg_mode |-> !reg_en;
    endproperty
    a_no_clock: assert property (p_no_clock) else $error("clock used outside mode");

    property p_empty_term;
        @(posedge clk_i) disable iff (!resetn_i)
        fuse_i[1] == '0 |-> sum[0];
    endproperty
    a_empty_term: assert property (p_empty_term) else $error("empty term not true");

    property p_outer_fb;
        @(posedge clk_i) disable iff (!resetn_i)
        mode_i == mixed_io_config
            |-> sig[FB_BASE+OUTER_LOW] == clk_pin_i && sig[FB_BASE+OUTER_HIGH] == oe_n_pin_i;
    endproperty
    a_outer_fb: assert property (p_outer_fb) else $error("outer feedback used");

endmodule : aoam_top

`default_nettype wire

// >>> bench/aoam_board.sv
/*
 * Model of the board logic around the array: dedicated inputs, clock pin,
 * shared enable pin and the resolved level of every macrocell pin.
 * Assumes the bench changes requests just after a rising clk_i edge.
 */
`timescale 1ns/1ps
`default_nettype none

module aoam_board (
    // Clock
    input wire logic clk_i,
    // Requests from the bench
    input wire logic [7:0] in_req_i,
    input wire logic clk_req_i,
    input wire logic oe_n_req_i,
    input wire logic [7:0] ext_val_i,
    input wire logic [7:0] ext_en_i,
    // Device pins
    input wire aoam_pkg::aoam_pin_type [aoam_pkg::NUM_CELLS-1:0] pin_i,
    output logic [7:0] in_o,
    output logic clk_pin_o,
    output logic oe_n_pin_o,
    output logic [7:0] io_o
);
    import aoam_pkg::*;

    logic [7:0] wobble = 8'h55;

    // Undriven pins float: a pattern that flips every cycle
    always @(posedge clk_i) begin
        wobble <= ~wobble;
    end

    // Dedicated pins pass straight to the device
    assign in_o = in_req_i;
    assign clk_pin_o = clk_req_i;
    assign oe_n_pin_o = oe_n_req_i;

    // Wire level: device driver first, then board driver, else floating
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            io_o[k] = pin_i[k].oe ? pin_i[k].out : (ext_en_i[k] ? ext_val_i[k] : wobble[k]);
        end
    end
endmodule : aoam_board

`default_nettype wire

// >>> bench/aoam_top_tb.sv
/*
 * Self-checking bench for the array: runs all three architecture modes.
 * Assumes the design resamples its outputs on clk_i and settles in 3 cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module aoam_top_tb;
    import aoam_pkg::*;

    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    aoam_mode_type mode = simple_combinational_config;
    aoam_cell_cfg_type [7:0] cfg = '0;
    aoam_cell_cfg_type [7:0] cz;
    logic [63:0][31:0] fuse = '0;
    logic [63:0][31:0] fz;
    logic [7:0] in_req = 8'h00;
    logic clk_req = 1'b0;
    logic oe_n_req = 1'b1;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] in_w;
    logic clk_w;
    logic oe_n_w;
    logic [7:0] io_w;
    aoam_pin_type [7:0] pin;
    logic [7:0] v;
    logic [7:0] f;
    logic [7:0] eoe;
    logic [7:0] eout;
    int err_total = 0;
    int samples_checked = 0;

    always #12.5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////
    // Device and board
    aoam_top i_aoam_top (.clk_i(clk_i), .resetn_i(resetn_i), .mode_i(mode),
        .cell_cfg_i(cfg), .fuse_i(fuse), .in_i(in_w), .clk_pin_i(clk_w),
        .oe_n_pin_i(oe_n_w), .io_i(io_w), .pin_o(pin));
    aoam_board i_aoam_board (.clk_i(clk_i), .in_req_i(in_req), .clk_req_i(clk_req),
        .oe_n_req_i(oe_n_req), .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_i(pin),
        .in_o(in_w), .clk_pin_o(clk_w), .oe_n_pin_o(oe_n_w), .io_o(io_w));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Gather pin levels (sel=0) or enables (sel=1)
    function automatic logic [7:0] bits(input logic sel);
        logic [7:0] r;
        for (int k = 0; k < 8; k++) r[k] = sel ? pin[k].oe : pin[k].out;
        return r;
    endfunction : bits

    // Load the staged fuse and cell pattern while reset is held
    task automatic restart(input aoam_mode_type m);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        mode <= m;
        cfg <= cz;
        fuse <= fz;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
    endtask : restart

    // Apply one set of pin levels and let the outputs settle
    task automatic drive(input logic [7:0] d, input logic c, input logic g, input logic e);
        @(posedge clk_i);
        in_req <= d;
        clk_req <= c;
        oe_n_req <= g;
        ext_val <= e ? 8'hff : 8'h00;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : drive

    task automatic final_report();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (2000) @(posedge clk_i);
        err_total++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        // Simple mode: term 8m+1 = in[m] AND NOT in[m+1]; odd cells active high
        fz = {64{32'h3}};
        for (int m = 0; m < 8; m++) begin
            fz[8*m+1] = (32'h1 << (2*m)) | (32'h2 << (2*((m+1)%8)));
            cz[m] = aoam_cell_cfg_type'({1'b1, m[0], 1'b0, m == 3});
        end
        restart(simple_combinational_config);
        for (int i = 0; i < 5; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'ha5 : (i == 3) ? 8'h3c : 8'h01;
            drive(v, 1'b0, 1'b1, 1'b0);
            f = v & ~{v[0], v[7:1]};
            check(bits(1'b0) & 8'hf7, (f ^ 8'h55) & 8'hf7);
            check(bits(1'b1), 8'hf7);
        end
        // Registered mode: cell0 reg = in0, cell1 = feedback of cell0, cell2 reg low
        fz = {64{32'h3}};
        fz[1] = 32'h1;
        fz[9] = 32'h1 << 16;
        fz[17] = 32'h1 << 4;
        cz = {{5{aoam_cell_cfg_type'(4'h1)}}, aoam_cell_cfg_type'(4'h8),
              aoam_cell_cfg_type'(4'h4), aoam_cell_cfg_type'(4'hc)};
        restart(registered_config);
        drive(8'h05, 1'b0, 1'b0, 1'b0);
        check(bits(1'b0) & 8'h07, 8'h00);
        check(bits(1'b1), 8'h07);
        drive(8'h05, 1'b1, 1'b0, 1'b0);
        check(bits(1'b0) & 8'h07, 8'h03);
        drive(8'h00, 1'b1, 1'b0, 1'b0);
        check(bits(1'b0) & 8'h07, 8'h03);
        drive(8'h00, 1'b0, 1'b1, 1'b0);
        check(bits(1'b1), 8'h02);
        check(bits(1'b0) & 8'h02, 8'h02);
        drive(8'h00, 1'b1, 1'b1, 1'b0);
        check(bits(1'b0) & 8'h02, 8'h00);
        drive(8'h00, 1'b0, 1'b0, 1'b0);
        check(bits(1'b0) & 8'h07, 8'h04);
        check(bits(1'b1), 8'h07);
        // Mixed mode: outer cells gated by in5, cell3 gated by in6 and fed by pin4
        fz = {64{32'h3}};
        fz[0] = 32'h1 << 10;
        fz[1] = 32'h1;
        fz[56] = 32'h1 << 10;
        fz[57] = 32'h1 << 14;
        fz[24] = 32'h1 << 12;
        fz[25] = 32'h1 << 24;
        fz[9] = 32'h1 << 16;
        cz = {aoam_cell_cfg_type'(4'h7), {3{aoam_cell_cfg_type'(4'h5)}},
              aoam_cell_cfg_type'(4'h6), aoam_cell_cfg_type'(4'h5),
              aoam_cell_cfg_type'(4'h4), aoam_cell_cfg_type'(4'h6)};
        restart(mixed_io_config);
        ext_en <= 8'h10;
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h20 : (i == 1) ? 8'h61 : (i == 2) ? 8'hff : 8'hc1;
            drive(v, i[1], 1'b1, i[0]);
            eoe = {v[5], 3'b000, v[6], 1'b0, 1'b1, v[5]};
            eout = {v[7], 3'b000, i[0], 1'b0, i[1], v[0]};
            check(bits(1'b1), eoe);
            check(bits(1'b0) & eoe, eout & eoe);
        end
        final_report();
    end
endmodule : aoam_top_tb

`default_nettype wire
